// ==== include/aets_defines.vh ====
`ifndef AETS_DEFINES_VH
`define AETS_DEFINES_VH
// Register byte offsets.
`define AETS_CTRL_OFS    8'h00
`define AETS_CLKCTL_OFS  8'h04
`define AETS_MUXCTL_OFS  8'h08
`define AETS_GPIO_OFS    8'h0C
`define AETS_IRQST_OFS   8'h10
`define AETS_IRQMSK_OFS  8'h14
`define AETS_STATUS_OFS  8'h18
`define AETS_GRP_BASE    32'h20
`define AETS_GRP_STRIDE  32'h10
// Offsets inside one group window.
`define AETS_GCFG_OFS    8'h00
`define AETS_GCHS_OFS    8'h04
`define AETS_GTHR_OFS    8'h08
`define AETS_GRES_OFS    8'h0C
// Control register fields.
`define AETS_CTRL_AUTOPD 0
`define AETS_CTRL_FMT_LO 1
`define AETS_FMT_12      2'h0
`define AETS_FMT_10      2'h1
`define AETS_FMT_8       2'h2
`define AETS_CLKDIV_MSB  4
`define AETS_MUX_DEF     0
`define AETS_MUX_ALT     1
`define AETS_GPIO_OE     0
`define AETS_GPIO_OUT    1
`define AETS_GPIO_IN     2
// Group configuration fields.
`define AETS_GCFG_SEL_LO 0
`define AETS_GCFG_HWEN   3
`define AETS_GCFG_CONT   4
`define AETS_GCFG_DMA    5
`define AETS_GCFG_SWST   6
`define AETS_GTHR_CNT_LO 0
`define AETS_GTHR_CH_LO  8
`define AETS_GTHR_VAL_LO 16
`define AETS_GTHR_GT     28
`define AETS_RES_VALID   31
// Interrupt status layout.
`define AETS_IRQ_THR_LO  0
`define AETS_IRQ_CMP_LO  3
// Reset values.
`define AETS_ZERO32      32'h0000_0000
`define AETS_CLKDIV_RST  5'h00
`define AETS_MUX_RST     2'h1
// Sizes and bus answers.
`define AETS_NGRP        3
`define AETS_BUF_DEPTH   4
`define AETS_RESP_OKAY   2'h0
`define AETS_RESP_SLVERR 2'h2
`endif

// ==== core/aets_core.v ====
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "aets_defines.vh"

// Contract
// - Three groups, each with eight trigger sources.
// - Default select map: pin, timers, compare, port.
// - Alternate map for the second converter.
// - Mux bit 0 set forces default wiring.
// - Bit 0 clear, bit 1 set: alternate wiring.
// - Pin triggers tapped after input buffer.
// - Timer triggers tapped at timer boundary.
// - Compare trigger taken directly from timer output.
// - Free channel allocation, one region per group.
// - Region serviced by interrupt or DMA request.
// - Threshold counter interrupt per group.
// - Magnitude compare interrupt on one channel.
// - Results read as 8, 10 or 12 bits.
// - Single sequence or continuous restart per group.
// - Optional automatic core power-down when idle.
// - Event pin usable as general-purpose I/O.
// - Converter clock divided by 5-bit prescale.
module aets_core (
  // Clock and reset.
  input  wire        i_core_clk,
  input  wire        i_rst,
  // AXI4-Lite slave.
  input  wire [7:0]  i_s_axi_awaddr,
  input  wire        i_s_axi_awvalid,
  output reg         o_s_axi_awready,
  input  wire [31:0] i_s_axi_wdata,
  input  wire [3:0]  i_s_axi_wstrb,
  input  wire        i_s_axi_wvalid,
  output reg         o_s_axi_wready,
  output reg  [1:0]  o_s_axi_bresp,
  output reg         o_s_axi_bvalid,
  input  wire        i_s_axi_bready,
  input  wire [7:0]  i_s_axi_araddr,
  input  wire        i_s_axi_arvalid,
  output reg         o_s_axi_arready,
  output reg  [31:0] o_s_axi_rdata,
  output reg  [1:0]  o_s_axi_rresp,
  output reg         o_s_axi_rvalid,
  input  wire        i_s_axi_rready,
  // Trigger sources.
  input  wire        i_converter_event_pin_in,
  input  wire        i_second_converter_event_pin,
  input  wire [3:0]  i_timer_channel,
  input  wire [3:0]  i_timer_one_channel,
  input  wire [1:0]  i_timer_two_channel,
  input  wire        i_interrupt_timer_cmp0,
  input  wire [1:0]  i_gpio_port_b,
  // Event pin drive.
  output reg         o_converter_event_pin_out,
  output reg         o_converter_event_pin_oe,
  // Converter core.
  output reg         o_conv_clk_en,
  output reg         o_conv_start,
  output reg  [3:0]  o_conv_chan,
  input  wire        i_conv_done,
  input  wire [11:0] i_conv_result,
  output reg         o_core_pd,
  // Service requests.
  output reg  [2:0]  o_dma_req,
  output reg         o_irq
);

  localparam [2:0] S_IDLE  = 3'b001;
  localparam [2:0] S_START = 3'b010;
  localparam [2:0] S_WAIT  = 3'b100;

  reg  [2:0]  ctrl_q;
  reg  [4:0]  clkdiv_q;
  reg  [4:0]  divcnt_q;
  reg  [1:0]  mux_q;
  reg  [5:0]  irqst_q;
  reg  [5:0]  irqmsk_q;
  reg  [7:0]  sync1_q;
  reg  [7:0]  sync2_q;
  reg  [7:0]  sync3_q;
  reg  [2:0]  state_q;
  reg  [1:0]  grp_q;
  reg  [15:0] mask_q;
  reg  [7:0]  waddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         aw_full_q;
  reg         w_full_q;
  wire        tick;
  wire        use_alt;
  wire [7:0]  def_src;
  wire [7:0]  alt_src;
  wire [7:0]  rise;
  wire        wr_en;
  wire        rd_en;
  wire [2:0]  pend;
  wire [2:0]  cont;
  wire [47:0] chsel;
  wire [2:0]  ev_thr;
  wire [2:0]  ev_cmp;
  wire [2:0]  dma_w;
  wire [2:0]  g_rhit;
  wire [2:0]  g_whit;
  wire [95:0] g_rdat;
  wire [2:0]  take;
  wire [1:0]  pick;
  wire        store;
  wire [15:0] cur_chs;
  reg  [32:0] rd_c;
  reg         c_whit;
  wire [31:0] ctrl_m;

  function [3:0] low_bit;
    input [15:0] m;
    integer k;
    begin
      low_bit = 4'h0;
      for (k = 15; k >= 0; k = k - 1) begin
        if (m[k]) begin
          low_bit = k[3:0];
        end
      end
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (st[k]) begin
          merge[8*k +: 8] = nw[8*k +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Converter clock enable from the prescaler.
  assign tick = (divcnt_q == clkdiv_q);

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      divcnt_q      <= `AETS_CLKDIV_RST;
      o_conv_clk_en <= 1'b0;
    end else begin
      divcnt_q      <= tick ? 5'h00 : divcnt_q + 5'h01;
      o_conv_clk_en <= tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger wiring and synchronisers.
  assign use_alt = ~mux_q[`AETS_MUX_DEF] & mux_q[`AETS_MUX_ALT];
  // Pin taps use the input-buffer side, timer taps the module side.
  assign def_src = {i_gpio_port_b[1], i_gpio_port_b[0], i_timer_channel[3], i_timer_channel[2],
                    i_interrupt_timer_cmp0, i_timer_channel[1], i_timer_channel[0],
                    i_converter_event_pin_in};
  assign alt_src = {i_timer_two_channel[1], i_timer_one_channel[3], i_timer_one_channel[2],
                    i_timer_one_channel[1], i_interrupt_timer_cmp0, i_timer_one_channel[0],
                    i_timer_two_channel[0], i_second_converter_event_pin};
  assign rise = sync2_q & ~sync3_q;

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      sync3_q <= 8'h00;
    end else begin
      sync1_q <= use_alt ? alt_src : def_src;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus handshakes.
  assign wr_en = aw_full_q & w_full_q & ~o_s_axi_bvalid;
  assign rd_en = i_s_axi_arvalid & o_s_axi_arready;

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= `AETS_RESP_OKAY;
      aw_full_q       <= 1'b0;
      w_full_q        <= 1'b0;
      waddr_q         <= 8'h00;
      wdata_q         <= `AETS_ZERO32;
      wstrb_q         <= 4'h0;
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= `AETS_ZERO32;
      o_s_axi_rresp   <= `AETS_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        waddr_q         <= i_s_axi_awaddr;
        aw_full_q       <= 1'b1;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        wdata_q        <= i_s_axi_wdata;
        wstrb_q        <= i_s_axi_wstrb;
        w_full_q       <= 1'b1;
        o_s_axi_wready <= 1'b0;
      end
      if (wr_en) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= (c_whit | (|g_whit)) ? `AETS_RESP_OKAY : `AETS_RESP_SLVERR;
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid  <= 1'b0;
        aw_full_q       <= 1'b0;
        w_full_q        <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
      if (rd_en) begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid  <= 1'b1;
        o_s_axi_rdata   <= rd_c[31:0];
        o_s_axi_rresp   <= rd_c[32] ? `AETS_RESP_OKAY : `AETS_RESP_SLVERR;
      end
      if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid  <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Common registers.
  assign ctrl_m = merge({29'h0, ctrl_q}, wdata_q, wstrb_q);

  always @* begin
    c_whit = (waddr_q == `AETS_CTRL_OFS) | (waddr_q == `AETS_CLKCTL_OFS) |
             (waddr_q == `AETS_MUXCTL_OFS) | (waddr_q == `AETS_GPIO_OFS) |
             (waddr_q == `AETS_IRQST_OFS) | (waddr_q == `AETS_IRQMSK_OFS) |
             (waddr_q == `AETS_STATUS_OFS);
    rd_c = {1'b0, `AETS_ZERO32};
    case (i_s_axi_araddr)
      `AETS_CTRL_OFS:   rd_c = {1'b1, 29'h0, ctrl_q};
      `AETS_CLKCTL_OFS: rd_c = {1'b1, 27'h0, clkdiv_q};
      `AETS_MUXCTL_OFS: rd_c = {1'b1, 30'h0, mux_q};
      `AETS_GPIO_OFS:   rd_c = {1'b1, 29'h0, i_converter_event_pin_in,
                                o_converter_event_pin_out, o_converter_event_pin_oe};
      `AETS_IRQST_OFS:  rd_c = {1'b1, 26'h0, irqst_q};
      `AETS_IRQMSK_OFS: rd_c = {1'b1, 26'h0, irqmsk_q};
      `AETS_STATUS_OFS: rd_c = {1'b1, 24'h0, pend, grp_q, state_q};
      default: begin
        if (|g_rhit) begin
          rd_c = {1'b1, g_rdat[31:0] | g_rdat[63:32] | g_rdat[95:64]};
        end
      end
    endcase
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q                    <= 3'h0;
      clkdiv_q                  <= `AETS_CLKDIV_RST;
      mux_q                     <= `AETS_MUX_RST;
      o_converter_event_pin_oe  <= 1'b0;
      o_converter_event_pin_out <= 1'b0;
      irqst_q                   <= 6'h00;
      irqmsk_q                  <= 6'h00;
      o_irq                     <= 1'b0;
      o_dma_req                 <= 3'h0;
      o_core_pd                 <= 1'b0;
    end else begin
      if (wr_en && waddr_q == `AETS_CTRL_OFS) begin
        ctrl_q <= ctrl_m[2:0];
      end
      if (wr_en && waddr_q == `AETS_CLKCTL_OFS && wstrb_q[0]) begin
        clkdiv_q <= wdata_q[`AETS_CLKDIV_MSB:0];
      end
      if (wr_en && waddr_q == `AETS_MUXCTL_OFS && wstrb_q[0]) begin
        mux_q <= wdata_q[1:0];
      end
      if (wr_en && waddr_q == `AETS_GPIO_OFS && wstrb_q[0]) begin
        o_converter_event_pin_oe  <= wdata_q[`AETS_GPIO_OE];
        o_converter_event_pin_out <= wdata_q[`AETS_GPIO_OUT];
      end
      if (wr_en && waddr_q == `AETS_IRQMSK_OFS && wstrb_q[0]) begin
        irqmsk_q <= wdata_q[5:0];
      end
      // New events win over a write-one clear in the same cycle.
      irqst_q <= (irqst_q & ~((wr_en && waddr_q == `AETS_IRQST_OFS && wstrb_q[0]) ? wdata_q[5:0] : 6'h00))
                 | {ev_cmp, ev_thr};
      o_irq     <= |(irqst_q & irqmsk_q);
      o_dma_req <= dma_w;
      o_core_pd <= ctrl_q[`AETS_CTRL_AUTOPD] & (state_q == S_IDLE) & ~(|pend);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer shared by the three groups.
  assign pick    = pend[0] ? 2'd0 : (pend[1] ? 2'd1 : 2'd2);
  assign take    = (state_q == S_IDLE && tick && |pend) ? (3'b001 << pick) : 3'b000;
  assign store   = (state_q == S_WAIT) & i_conv_done;
  assign cur_chs = chsel[16*grp_q +: 16];

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q      <= S_IDLE;
      grp_q        <= 2'd0;
      mask_q       <= 16'h0000;
      o_conv_start <= 1'b0;
      o_conv_chan  <= 4'h0;
    end else begin
      o_conv_start <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (tick && |pend) begin
            grp_q   <= pick;
            mask_q  <= chsel[16*pick +: 16];
            state_q <= S_START;
          end
        end
        S_START: begin
          if (mask_q == 16'h0000) begin
            state_q <= S_IDLE;
          end else if (tick) begin
            o_conv_start <= 1'b1;
            o_conv_chan  <= low_bit(mask_q);
            state_q      <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (i_conv_done) begin
            if ((mask_q & ~(16'h0001 << o_conv_chan)) != 16'h0000) begin
              mask_q  <= mask_q & ~(16'h0001 << o_conv_chan);
              state_q <= S_START;
            end else if (cont[grp_q]) begin
              mask_q  <= cur_chs;
              state_q <= S_START;
            end else begin
              mask_q  <= 16'h0000;
              state_q <= S_IDLE;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-group configuration, trigger and result region.
  genvar g;
  generate
    for (g = 0; g < `AETS_NGRP; g = g + 1) begin : grp
      localparam integer GB = `AETS_GRP_BASE + g * `AETS_GRP_STRIDE;
      reg  [5:0]  cfg_q;
      reg  [15:0] chs_q;
      reg  [28:0] thr_q;
      reg         pend_q;
      reg  [15:0] buf_q [0:3];
      reg  [1:0]  wp_q;
      reg  [1:0]  rp_q;
      reg  [2:0]  cnt_q;
      wire        wcfg;
      wire        push;
      wire        pop;
      wire        trig;
      wire [2:0]  cnt_n;
      wire [11:0] head;
      wire [11:0] fmt;
      wire [2:0]  lim;
      wire        ahit;
      wire [31:0] cfg_m;
      wire [31:0] chs_m;
      wire [31:0] thr_m;

      assign wcfg  = wr_en && waddr_q == (GB[7:0] + `AETS_GCFG_OFS);
      assign cfg_m = merge({26'h0, cfg_q}, wdata_q, wstrb_q);
      assign chs_m = merge({16'h0, chs_q}, wdata_q, wstrb_q);
      assign thr_m = merge({3'h0, thr_q}, wdata_q, wstrb_q);
      assign trig  = cfg_q[`AETS_GCFG_HWEN] & rise[cfg_q[2:0]];
      assign push  = store && grp_q == g && cnt_q != `AETS_BUF_DEPTH;
      assign ahit  = i_s_axi_araddr == (GB[7:0] + `AETS_GRES_OFS);
      assign pop   = rd_en && ahit && cnt_q != 3'd0;
      assign cnt_n = cnt_q + {2'b00, push} - {2'b00, pop};
      assign lim   = (thr_q[2:0] == 3'd0) ? 3'd1 : thr_q[2:0];
      assign head  = buf_q[rp_q][11:0];
      assign fmt   = (ctrl_q[2:1] == `AETS_FMT_8)  ? {4'h0, head[11:4]} :
                     (ctrl_q[2:1] == `AETS_FMT_10) ? {2'b00, head[11:2]} : head;
      assign pend[g]         = pend_q;
      assign cont[g]         = cfg_q[`AETS_GCFG_CONT];
      assign chsel[16*g +: 16] = chs_q;
      assign ev_thr[g] = push && cnt_n == lim && !cfg_q[`AETS_GCFG_DMA];
      assign ev_cmp[g] = push && o_conv_chan == thr_q[11:8] &&
                         (thr_q[`AETS_GTHR_GT] ? (i_conv_result > thr_q[27:16])
                                               : (i_conv_result < thr_q[27:16]));
      assign dma_w[g]  = cfg_q[`AETS_GCFG_DMA] && cnt_q >= lim;
      assign g_whit[g] = waddr_q[7:4] == GB[7:4] && waddr_q[1:0] == 2'b00;
      assign g_rhit[g] = i_s_axi_araddr[7:4] == GB[7:4] && i_s_axi_araddr[1:0] == 2'b00;
      assign g_rdat[32*g +: 32] =
        !g_rhit[g] ? `AETS_ZERO32 :
        (i_s_axi_araddr[3:2] == 2'd0) ? {26'h0, cfg_q} :
        (i_s_axi_araddr[3:2] == 2'd1) ? {16'h0, chs_q} :
        (i_s_axi_araddr[3:2] == 2'd2) ? {3'h0, thr_q} :
        {cnt_q != 3'd0, 11'h0, buf_q[rp_q][15:12], 4'h0, fmt};

      always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          cfg_q  <= 6'h00;
          chs_q  <= 16'h0000;
          thr_q  <= 29'h0;
          pend_q <= 1'b0;
          wp_q   <= 2'd0;
          rp_q   <= 2'd0;
          cnt_q  <= 3'd0;
        end else begin
          if (wcfg) begin
            cfg_q <= cfg_m[5:0];
          end
          if (wr_en && waddr_q == (GB[7:0] + `AETS_GCHS_OFS)) begin
            chs_q <= chs_m[15:0];
          end
          if (wr_en && waddr_q == (GB[7:0] + `AETS_GTHR_OFS)) begin
            thr_q <= thr_m[28:0];
          end
          // A new trigger survives the cycle in which the sequencer takes the group.
          pend_q <= (pend_q & ~take[g]) | trig |
                    (wcfg & wstrb_q[0] & wdata_q[`AETS_GCFG_SWST]);
          if (push) begin
            buf_q[wp_q] <= {o_conv_chan, i_conv_result};
            wp_q        <= wp_q + 2'd1;
          end
          if (pop) begin
            rp_q <= rp_q + 2'd1;
          end
          cnt_q <= cnt_n;
        end
      end
    end
  endgenerate

endmodule

// ==== tb/aets_conv_model.sv ====
`timescale 1ns/1ps
// Converter core stand-in: one result per start, after i_lat cycles.
module aets_conv_model (
  input  wire        i_core_clk,
  input  wire        i_rst,
  input  wire [3:0]  i_lat,
  input  wire        i_conv_start,
  input  wire [3:0]  i_conv_chan,
  output reg         o_conv_done,
  output reg  [11:0] o_conv_result
);
  reg [3:0] chan_q;
  reg [3:0] cnt_q;
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_conv_done <= 1'b0;
      o_conv_result <= 12'hFFF;
      chan_q <= 4'h0;
      cnt_q <= 4'h0;
    end else begin
      o_conv_done <= 1'b0;
      // Outside an answer the result lines do not hold a stale value.
      o_conv_result <= ~o_conv_result;
      if (i_conv_start) begin
        chan_q <= i_conv_chan;
        cnt_q <= i_lat;
      end else if (cnt_q == 4'h1) begin
        o_conv_done <= 1'b1;
        o_conv_result <= {4'h9, chan_q, ~chan_q};
        cnt_q <= 4'h0;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

// ==== tb/aets_core_checker.sv ====
`timescale 1ns/1ps
module aets_core_checker (
  input wire        i_core_clk,
  input wire        i_rst,
  input wire        i_s_axi_awvalid,
  input wire        o_s_axi_awready,
  input wire        i_s_axi_wvalid,
  input wire        o_s_axi_wready,
  input wire [1:0]  o_s_axi_bresp,
  input wire        o_s_axi_bvalid,
  input wire        i_s_axi_bready,
  input wire        i_s_axi_arvalid,
  input wire        o_s_axi_arready,
  input wire [31:0] o_s_axi_rdata,
  input wire        o_s_axi_rvalid,
  input wire        i_s_axi_rready,
  input wire        o_conv_start,
  input wire        o_core_pd
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  a_b_follows: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
    |-> ##2 o_s_axi_bvalid) else $error("write response late");
  a_b_holds: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped");
  a_wr_blocked: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken while response pending");
  a_r_follows: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read data late");
  a_r_holds: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped");
  a_rd_ready_back: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid && o_s_axi_arready)
    else $error("read channel not released");
  a_start_pulse: assert property ($rose(o_conv_start) |=> !o_conv_start)
    else $error("start longer than one cycle");
  a_pd_busy: assert property (o_conv_start |-> !o_core_pd)
    else $error("core powered down at start");
endmodule
bind aets_core aets_core_checker u_chk (.i_core_clk, .i_rst, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid,
  .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid, .o_s_axi_arready,
  .o_s_axi_rdata, .o_s_axi_rvalid, .i_s_axi_rready, .o_conv_start, .o_core_pd);

// ==== tb/aets_core_tb_top.sv ====
`timescale 1ns/1ps
module aets_core_tb_top;
  logic        i_core_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd_q;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [15:0] sv = 16'h0;
  logic [3:0]  lat = 4'h1, last_chan;
  logic [1:0]  rsp_q, bresp, rresp;
  logic [31:0] rdata;
  logic [11:0] res;
  logic [3:0]  chan;
  logic [2:0]  dma;
  logic        awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, clk_en, start, done, pd, irq;
  int          n_errors = 0, tests_run = 0, n_start = 0;
  int          muxv[4] = '{1, 3, 2, 0};
  int          m, g, c;
  // The pad: the event pin sees its own drive when enabled.
  wire         pin_in = pin_oe ? pin_out : sv[0];
  aets_core DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_converter_event_pin_in(pin_in),
    .i_second_converter_event_pin(sv[8]), .i_timer_channel({sv[5], sv[4], sv[2], sv[1]}),
    .i_timer_one_channel({sv[14], sv[13], sv[12], sv[10]}), .i_timer_two_channel({sv[15], sv[9]}),
    .i_interrupt_timer_cmp0(sv[3]), .i_gpio_port_b(sv[7:6]), .o_converter_event_pin_out(pin_out),
    .o_converter_event_pin_oe(pin_oe), .o_conv_clk_en(clk_en), .o_conv_start(start), .o_conv_chan(chan),
    .i_conv_done(done), .i_conv_result(res), .o_core_pd(pd), .o_dma_req(dma), .o_irq(irq));
  aets_conv_model u_conv (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_lat(lat), .i_conv_start(start),
    .i_conv_chan(chan), .o_conv_done(done), .o_conv_result(res));
  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    if (start === 1'b1) begin
      n_start++;
      last_chan = chan;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rsp_q = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_core_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_q = rdata;
    rsp_q = rresp;
  endtask
  task automatic pulse(input int i);
    @(posedge i_core_clk);
    sv[i] <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    sv[i] <= 1'b0;
  endtask
  task automatic wait_start(input int s0, input logic [3:0] ch);
    for (int k = 0; k < 200 && n_start == s0; k++) @(posedge i_core_clk);
    chk("start_chan", {28'h0, last_chan}, {28'h0, ch});
  endtask
  task automatic drain(input logic [7:0] a, input logic [31:0] exp);
    rd_q = 32'h0;
    for (int k = 0; k < 20 && rd_q[31] !== 1'b1; k++) rd(a);
    chk("result", rd_q & 32'h800F0FFF, exp);
  endtask
  task automatic trig(input int g, input int c, input bit alt);
    logic [3:0] ch;
    logic [7:0] b;
    int s0;
    ch = 4'((c + 5 * g) % 16);
    b = 8'(8'h20 + 8'h10 * g);
    wr(b + 8'h4, 32'h1 << ch);
    wr(b, 32'h8 | c);
    s0 = n_start;
    if (c != 3) begin
      pulse(alt ? c : c + 8);
      repeat (20) @(posedge i_core_clk);
      chk("other_map_idle", n_start, s0);
    end
    pulse((alt && c != 3) ? c + 8 : c);
    wait_start(s0, ch);
    drain(b + 8'hC, {1'b1, 11'h0, ch, 4'h0, 4'h9, ch, ~ch});
    wr(b, 32'h0);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #300us;
    n_errors++;
    $display("watchdog expired");
    conclude();
  end
  initial begin
    int s0, k;
    repeat (8) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rd(8'h08);
    chk("muxctl_reset", rd_q, 32'h1);
    rd(8'h04);
    chk("clkctl_reset", rd_q, 32'h0);
    rd(8'hFC);
    chk("unmapped_rd", {rsp_q, rd_q[29:0]}, 32'h80000000);
    wr(8'hFC, 32'h1);
    chk("unmapped_wr", {30'h0, rsp_q}, 32'h2);
    $display("test reset done");
    for (m = 0; m < 4; m++) begin
      wr(8'h08, 32'(muxv[m]));
      for (g = 0; g < 3; g++) for (c = 0; c < 8; c++) trig(g, c, muxv[m] == 2);
    end
    wr(8'h08, 32'h1);
    $display("test trigger maps done");
    wr(8'h24, 32'h1);
    wr(8'h20, 32'h8);
    wr(8'h0C, 32'h1);
    rd(8'h0C);
    chk("pin_low", rd_q & 32'h4, 32'h0);
    s0 = n_start;
    wr(8'h0C, 32'h3);
    wait_start(s0, 4'h0);
    rd(8'h0C);
    chk("pin_high", rd_q & 32'h4, 32'h4);
    drain(8'h2C, 32'h8000090F);
    wr(8'h20, 32'h0);
    wr(8'h0C, 32'h0);
    $display("test event pin done");
    wr(8'h04, 32'h3);
    do @(posedge i_core_clk); while (clk_en !== 1'b1);
    for (k = 1; k < 40; k++) begin
      @(posedge i_core_clk);
      if (clk_en === 1'b1) break;
    end
    chk("tick_period", k, 4);
    wr(8'h04, 32'h0);
    $display("test prescale done");
    wr(8'h00, 32'h5);
    repeat (3) @(posedge i_core_clk);
    chk("autopd", {31'h0, pd}, 32'h1);
    wr(8'h10, 32'h3F);
    wr(8'h14, 32'h3F);
    lat <= 4'hC;
    wr(8'h34, 32'h80);
    wr(8'h38, 32'h10000700);
    s0 = n_start;
    wr(8'h30, 32'h40);
    wait_start(s0, 4'h7);
    for (k = 0; k < 100 && irq !== 1'b1; k++) @(posedge i_core_clk);
    chk("irq_raised", {31'h0, irq}, 32'h1);
    rd(8'h10);
    chk("irq_status", rd_q, 32'h12);
    drain(8'h3C, 32'h80070097);
    wr(8'h10, 32'h12);
    repeat (2) @(posedge i_core_clk);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    $display("test interrupts done");
    wr(8'h44, 32'h1);
    s0 = n_start;
    wr(8'h40, 32'h60);
    wait_start(s0, 4'h0);
    for (k = 0; k < 100 && dma[2] !== 1'b1; k++) @(posedge i_core_clk);
    rd(8'h10);
    chk("dma_no_irq", {dma, rd_q[2:0]}, 32'h20);
    wr(8'h00, 32'h3);
    drain(8'h4C, 32'h80000243);
    @(posedge i_core_clk);
    chk("dma_release", {29'h0, dma}, 32'h0);
    $display("test dma done");
    wr(8'h24, 32'h1);
    s0 = n_start;
    wr(8'h20, 32'h50);
    repeat (200) @(posedge i_core_clk);
    chk("restarts", {31'h0, n_start - s0 >= 3}, 32'h1);
    wr(8'h20, 32'h0);
    repeat (40) @(posedge i_core_clk);
    s0 = n_start;
    repeat (100) @(posedge i_core_clk);
    chk("stopped", n_start, s0);
    $display("test continuous done");
    conclude();
  end
endmodule
